// File: diag_led_alarm_consts.vh
`ifndef DIAG_LED_ALARM_CONSTS_VH
`define DIAG_LED_ALARM_CONSTS_VH

// apb byte addresses
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_ALM_CNT 8'h08
`define A_SEL 8'h0c
`define A_SEL_CODE 8'h10
`define A_SEL_FIXED 8'h14
`define A_SEL_FLOAT 8'h18
`define A_LEDS 8'h1c
`define A_CMD 8'h20

// ctrl register field positions
`define C_BOOT_DONE 0
`define C_COMMISSION 1
`define C_CARD_WRITE 2
`define C_FW_WAIT 3
`define C_FAULT 4
`define C_CARD_BAD 5
`define C_ETH_OK 6
`define C_NAMING 7
`define C_BUS_TYPE_LO 8
`define C_BUS_TYPE_HI 9
`define C_RS_PD 10
`define C_RS_ACTIVE 11
`define C_FW_UPDATE 12
`define C_TOK_CFG 13
`define C_TOK_BUS 14
`define C_PROT_LO 16
`define C_PROT_HI 23
`define C_SAFE_EN 24
`define C_SAFE_ACT 25
`define C_SAFE_FLT 26
`define C_CAN_LO 28
`define C_CAN_HI 30
`define CTRL_RESET 32'h0000_0000

// bus variants
`define BUS_RS485 2'h0
`define BUS_TOKEN 2'h1
`define BUS_CAN 2'h2

// can states shown on the bus led
`define CAN_OPER 3'h0
`define CAN_PREOP 3'h1
`define CAN_STOP 3'h2
`define CAN_NOBUS 3'h3
`define CAN_WARN 3'h4
`define CAN_ERRCTL 3'h5

// drive status word bits
`define SW_FAULT 3
`define SW_ALARM 7

// command register
`define CMD_CLEAR 0

// history placement
`define HIST_BASE 6'h08
`define OVERWRITE_SLOT 3'h6

// flash timing
`define CLK_PERIOD_NS 10
`define FLASH_TICK_NS 100000000

`endif

// File: diag_led_alarm_buffer.v
// Summary of operation
// - ready led orange until boot completes
// - ready green: steady, slow commissioning, fast card
// - ready red: slow await power cycle, fast fault
// - bad card: ready, bus fast red
// - link green steady, slow naming, else off
// - rs485 bus: on, slow red, fast red
// - bus yellow variable flash during firmware update
// - token bus: off, slow cfg, fast fault
// - safety yellow: steady, slow active, fast fault
// - can green: steady, fast, single flash
// - can red: steady, single, double flash
// - alarms self-clear, need no acknowledgement
// - status bit 7 while alarm pending
// - store code, fixed and float value
// - removed alarms stay, marked removed
// - next entry for each alarm, count all
// - eight entries, full overwrites next-to-last
// - 56-entry history takes removed alarms only
// - full plus new alarm moves removed
// - history reverse order, youngest at eight
// - compact remaining buffer entries
// - full history drops oldest entries
// - counter write zero moves removed alarms
`include "diag_led_alarm_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module diag_led_alarm_buffer #(
  parameter [31:0] FLASH_TICK_CYC = `FLASH_TICK_NS / `CLK_PERIOD_NS, // fast half period
  parameter CODE_W = 16, // alarm code width
  parameter CNT_W = 16 // alarm counter width
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, low
  input wire [7:0] paddr, // apb address
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error, unmapped
  input wire alarm_in_valid, // new alarm pulse
  input wire [CODE_W-1:0] alarm_in_code, // new alarm code
  input wire [31:0] alarm_in_fixed, // fixed point value
  input wire [31:0] alarm_in_float, // float value
  input wire alarm_gone_valid, // cause removed pulse
  input wire [CODE_W-1:0] alarm_gone_code, // removed alarm code
  output reg [15:0] drive_status_word, // status word
  output reg ready_led_red, // ready led red
  output reg ready_led_green, // ready led green
  output reg bus_fault_led_red, // bus led red
  output reg bus_fault_led_green, // bus led green
  output reg link_led, // link led green
  output reg safety_led // safety led yellow
);

  localparam [31:0] TICK_LAST = FLASH_TICK_CYC - 32'h1; // divider terminal count
  localparam BUF_N = 8; // buffer depth
  localparam HIST_N = 56; // history depth
  // control and apb state
  reg [31:0] ctrl_r; // inverter state bits from software
  reg boot_r; // start-up finished
  reg [5:0] sel_r; // read-out index 0..63
  reg [CNT_W-1:0] cnt_r; // alarm counter
  reg [CNT_W-1:0] cnt_nxt; // next counter
  reg [31:0] rd_val; // read mux
  reg hit; // address decoded
  // flash pattern generator
  reg [31:0] tick_r; // divider
  reg [3:0] step_r; // pattern step
  // alarm buffer
  reg [CODE_W-1:0] bcode [0:BUF_N-1]; // codes
  reg [31:0] bfix [0:BUF_N-1]; // fixed values
  reg [31:0] bflt [0:BUF_N-1]; // float values
  reg [BUF_N-1:0] bval_r; // entry occupied
  reg [BUF_N-1:0] brem_r; // cause removed
  reg [3:0] n_r; // occupied count
  // alarm history, slot 0 is index 8
  reg [CODE_W-1:0] hcode [0:HIST_N-1]; // codes
  reg [31:0] hfix [0:HIST_N-1]; // fixed values
  reg [31:0] hflt [0:HIST_N-1]; // float values
  reg [HIST_N-1:0] hval_r; // slot occupied
  // next state copies
  reg [CODE_W-1:0] bcode_nxt [0:BUF_N-1];
  reg [31:0] bfix_nxt [0:BUF_N-1];
  reg [31:0] bflt_nxt [0:BUF_N-1];
  reg [BUF_N-1:0] bval_nxt;
  reg [BUF_N-1:0] brem_nxt;
  reg [3:0] n_nxt;
  reg [CODE_W-1:0] hcode_nxt [0:HIST_N-1];
  reg [31:0] hfix_nxt [0:HIST_N-1];
  reg [31:0] hflt_nxt [0:HIST_N-1];
  reg [HIST_N-1:0] hval_nxt;
  // led next values
  reg rdy_r_nxt;
  reg rdy_g_nxt;
  reg bus_r_nxt;
  reg bus_g_nxt;
  reg lnk_nxt;
  reg safe_nxt;
  integer i;
  integer j;
  integer k;
  integer m;
  integer p; // storage loops only, keeps one driver per variable
  wire req = psel && penable && !pready; // access phase, before answer
  wire fire = psel && penable && pready; // transfer completes this edge
  wire wr = fire && pwrite;
  wire clr = wr && (paddr == `A_CMD) && pwdata[`CMD_CLEAR];
  wire cnt_wr = wr && (paddr == `A_ALM_CNT);
  wire [5:0] hidx = sel_r - `HIST_BASE;
  wire [1:0] bus_type = ctrl_r[`C_BUS_TYPE_HI:`C_BUS_TYPE_LO];
  wire [2:0] can_st = ctrl_r[`C_CAN_HI:`C_CAN_LO];
  wire pending = |(bval_r & ~brem_r); // alarm not yet self-cleared
  // pattern phases; slow is a quarter of fast
  wire f_fast = step_r[0];
  wire f_slow = step_r[2];
  wire f_single = (step_r[2:0] == 3'h0);
  wire f_double = (step_r[2:0] == 3'h0) || (step_r[2:0] == 3'h2);
  wire f_var = step_r[3] ? step_r[0] : step_r[2]; // frequency alternates
  // divider and step counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r <= 32'h0;
      step_r <= 4'h0;
    end else if (tick_r >= TICK_LAST) begin
      tick_r <= 32'h0;
      step_r <= step_r + 4'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end
  // led decoding
  always @* begin
    // ready led
    if (!boot_r) begin
      {rdy_r_nxt, rdy_g_nxt} = 2'b11;
    end else if (ctrl_r[`C_CARD_BAD] || ctrl_r[`C_FAULT]) begin
      {rdy_r_nxt, rdy_g_nxt} = {f_fast, 1'b0};
    end else if (ctrl_r[`C_FW_WAIT]) begin
      {rdy_r_nxt, rdy_g_nxt} = {f_slow, 1'b0};
    end else if (ctrl_r[`C_CARD_WRITE]) begin
      {rdy_r_nxt, rdy_g_nxt} = {1'b0, f_fast};
    end else if (ctrl_r[`C_COMMISSION]) begin
      {rdy_r_nxt, rdy_g_nxt} = {1'b0, f_slow};
    end else begin
      {rdy_r_nxt, rdy_g_nxt} = 2'b01;
    end
    // bus led; a bad card overrides the bus view
    bus_r_nxt = 1'b0;
    bus_g_nxt = 1'b0;
    if (!boot_r) begin
      bus_r_nxt = 1'b0; // dark until start-up ends
    end else if (ctrl_r[`C_CARD_BAD]) begin
      bus_r_nxt = f_fast;
    end else if (ctrl_r[`C_FW_UPDATE]) begin
      {bus_r_nxt, bus_g_nxt} = {f_var, f_var};
    end else begin
      case (bus_type)
        `BUS_RS485: begin
          if (ctrl_r[`C_RS_PD]) begin
            bus_g_nxt = 1'b1;
          end else if (ctrl_r[`C_RS_ACTIVE]) begin
            bus_r_nxt = f_slow;
          end else begin
            bus_r_nxt = f_fast;
          end
        end
        `BUS_TOKEN: begin
          if (ctrl_r[`C_PROT_HI:`C_PROT_LO] == 8'h00) begin
            bus_r_nxt = 1'b0;
          end else if (ctrl_r[`C_TOK_CFG]) begin
            bus_r_nxt = f_slow;
          end else if (ctrl_r[`C_TOK_BUS]) begin
            bus_r_nxt = f_fast;
          end
        end
        `BUS_CAN: begin
          case (can_st)
            `CAN_OPER: bus_g_nxt = 1'b1;
            `CAN_PREOP: bus_g_nxt = f_fast;
            `CAN_STOP: bus_g_nxt = f_single;
            `CAN_NOBUS: bus_r_nxt = 1'b1;
            `CAN_WARN: bus_r_nxt = f_single;
            `CAN_ERRCTL: bus_r_nxt = f_double;
            default: bus_r_nxt = 1'b0;
          endcase
        end
        default: bus_r_nxt = 1'b0;
      endcase
    end
    // link led, naming takes precedence over plain link
    lnk_nxt = boot_r && (ctrl_r[`C_NAMING] ? f_slow : ctrl_r[`C_ETH_OK]);
    // safety led, dark until start-up ends; a fault outranks activity
    safe_nxt = boot_r && (ctrl_r[`C_SAFE_FLT] ? f_fast :
                          (ctrl_r[`C_SAFE_ACT] ? f_slow : ctrl_r[`C_SAFE_EN]));
  end

  // alarm buffer and history next state
  always @* begin
    for (i = 0; i < BUF_N; i = i + 1) begin
      bcode_nxt[i] = bcode[i];
      bfix_nxt[i] = bfix[i];
      bflt_nxt[i] = bflt[i];
    end
    for (j = 0; j < HIST_N; j = j + 1) begin
      hcode_nxt[j] = hcode[j];
      hfix_nxt[j] = hfix[j];
      hflt_nxt[j] = hflt[j];
    end
    bval_nxt = bval_r;
    brem_nxt = brem_r;
    hval_nxt = hval_r;
    n_nxt = n_r;
    k = 0;
    m = 0;
    // mark removed but keep the entry
    for (i = 0; i < BUF_N; i = i + 1) begin
      if (alarm_gone_valid && bval_r[i] && (bcode[i] == alarm_gone_code)) begin
        brem_nxt[i] = 1'b1;
      end
    end
    for (i = 0; i < BUF_N; i = i + 1) begin
      if (bval_nxt[i] && brem_nxt[i]) begin
        k = k + 1;
      end
    end
    // move removed entries on overflow or counter zeroing
    if ((k > 0) && ((alarm_in_valid && (n_r == 4'h8)) || (cnt_wr && (pwdata[CNT_W-1:0] == {CNT_W{1'b0}})))) begin
      for (j = HIST_N - 1; j >= 0; j = j - 1) begin
        if (j >= k) begin
          hcode_nxt[j] = hcode[j-k];
          hfix_nxt[j] = hfix[j-k];
          hflt_nxt[j] = hflt[j-k];
          hval_nxt[j] = hval_r[j-k];
        end
      end
      for (i = BUF_N - 1; i >= 0; i = i - 1) begin
        if (bval_nxt[i] && brem_nxt[i]) begin
          hcode_nxt[m] = bcode[i];
          hfix_nxt[m] = bfix[i];
          hflt_nxt[m] = bflt[i];
          hval_nxt[m] = 1'b1;
          m = m + 1;
        end
      end
      m = 0;
      for (i = 0; i < BUF_N; i = i + 1) begin
        if (bval_r[i] && !brem_nxt[i]) begin
          bcode_nxt[m] = bcode[i];
          bfix_nxt[m] = bfix[i];
          bflt_nxt[m] = bflt[i];
          m = m + 1;
        end
      end
      for (i = 0; i < BUF_N; i = i + 1) begin
        bval_nxt[i] = (i < m);
        brem_nxt[i] = 1'b0;
      end
      n_nxt = m[3:0];
    end
    // store the new alarm
    if (alarm_in_valid) begin
      if (n_nxt < 4'h8) begin
        bcode_nxt[n_nxt[2:0]] = alarm_in_code;
        bfix_nxt[n_nxt[2:0]] = alarm_in_fixed;
        bflt_nxt[n_nxt[2:0]] = alarm_in_float;
        bval_nxt[n_nxt[2:0]] = 1'b1;
        brem_nxt[n_nxt[2:0]] = 1'b0;
        n_nxt = n_nxt + 4'h1;
      end else begin
        bcode_nxt[`OVERWRITE_SLOT] = alarm_in_code;
        bfix_nxt[`OVERWRITE_SLOT] = alarm_in_fixed;
        bflt_nxt[`OVERWRITE_SLOT] = alarm_in_float;
        brem_nxt[`OVERWRITE_SLOT] = 1'b0;
      end
    end
    // counter write, then count the alarm so none is lost
    cnt_nxt = cnt_wr ? pwdata[CNT_W-1:0] : cnt_r;
    if (alarm_in_valid) begin
      cnt_nxt = cnt_nxt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // entry data, no reset needed since valid bits gate it
  always @(posedge pclk) begin
    for (p = 0; p < BUF_N; p = p + 1) begin
      bcode[p] <= bcode_nxt[p];
      bfix[p] <= bfix_nxt[p];
      bflt[p] <= bflt_nxt[p];
    end
    for (p = 0; p < HIST_N; p = p + 1) begin
      hcode[p] <= hcode_nxt[p];
      hfix[p] <= hfix_nxt[p];
      hflt[p] <= hflt_nxt[p];
    end
  end

  // read mux
  always @* begin
    hit = 1'b1;
    case (paddr)
      `A_CTRL: rd_val = ctrl_r;
      `A_STATUS: rd_val = {16'h0, drive_status_word};
      `A_ALM_CNT: rd_val = {{(32-CNT_W){1'b0}}, cnt_r};
      `A_SEL: rd_val = {26'h0, sel_r};
      `A_SEL_CODE: begin
        if (sel_r < `HIST_BASE) begin
          rd_val = {bval_r[sel_r[2:0]], brem_r[sel_r[2:0]], {(30-CODE_W){1'b0}}, bcode[sel_r[2:0]]};
        end else begin
          rd_val = {hval_r[hidx], 1'b1, {(30-CODE_W){1'b0}}, hcode[hidx]};
        end
      end
      `A_SEL_FIXED: rd_val = (sel_r < `HIST_BASE) ? bfix[sel_r[2:0]] : hfix[hidx];
      `A_SEL_FLOAT: rd_val = (sel_r < `HIST_BASE) ? bflt[sel_r[2:0]] : hflt[hidx];
      `A_LEDS: rd_val = {26'h0, safety_led, link_led, bus_fault_led_green, bus_fault_led_red,
                         ready_led_green, ready_led_red};
      `A_CMD: rd_val = 32'h0;
      default: begin
        rd_val = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  // control registers, apb answer, counters and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CTRL_RESET;
      boot_r <= 1'b0;
      sel_r <= 6'h0;
      cnt_r <= {CNT_W{1'b0}};
      bval_r <= {BUF_N{1'b0}};
      brem_r <= {BUF_N{1'b0}};
      hval_r <= {HIST_N{1'b0}};
      n_r <= 4'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      drive_status_word <= 16'h0;
      ready_led_red <= 1'b1;
      ready_led_green <= 1'b1;
      bus_fault_led_red <= 1'b0;
      bus_fault_led_green <= 1'b0;
      link_led <= 1'b0;
      safety_led <= 1'b0;
    end else begin
      // one wait state: answer comes the cycle after access begins
      pready <= req;
      if (req) begin
        prdata <= pwrite ? 32'h0 : rd_val;
      end
      pslverr <= req && !hit; // error only stands beside ready
      if (wr && (paddr == `A_CTRL)) begin
        ctrl_r <= pwdata;
      end
      if (wr && (paddr == `A_SEL)) begin
        sel_r <= pwdata[5:0];
      end
      // boot completes once software reports a settled state
      if (wr && (paddr == `A_CTRL) && pwdata[`C_BOOT_DONE]) begin
        boot_r <= 1'b1;
      end
      if (clr) begin
        boot_r <= 1'b0;
        cnt_r <= {CNT_W{1'b0}};
        bval_r <= {BUF_N{1'b0}};
        brem_r <= {BUF_N{1'b0}};
        hval_r <= {HIST_N{1'b0}};
        n_r <= 4'h0;
      end else begin
        cnt_r <= cnt_nxt;
        bval_r <= bval_nxt;
        brem_r <= brem_nxt;
        hval_r <= hval_nxt;
        n_r <= n_nxt;
      end
      drive_status_word <= 16'h0;
      drive_status_word[`SW_ALARM] <= pending;
      drive_status_word[`SW_FAULT] <= ctrl_r[`C_FAULT];
      ready_led_red <= rdy_r_nxt;
      ready_led_green <= rdy_g_nxt;
      bus_fault_led_red <= bus_r_nxt;
      bus_fault_led_green <= bus_g_nxt;
      link_led <= lnk_nxt;
      safety_led <= safe_nxt;
    end
  end

endmodule // diag_led_alarm_buffer

`default_nettype wire

// File: diag_led_alarm_buffer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module diag_led_alarm_buffer_sva (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [31:0] prdata, // read data
  input wire logic alarm_in_valid, // new alarm
  input wire logic alarm_gone_valid, // cause gone
  input wire logic [15:0] drive_status_word, // status word
  input wire logic ready_led_red, // ready red
  input wire logic ready_led_green, // ready green
  input wire logic bus_fault_led_red, // bus red
  input wire logic bus_fault_led_green, // bus green
  input wire logic link_led, // link led
  input wire logic safety_led // safety led
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // first access cycle, before the wait state ends
  sequence s_access;
    psel && penable && !pready;
  endsequence
  // alarm taken while no removal or clear can disturb the flag
  sequence s_quiet_alarm;
    alarm_in_valid && !alarm_gone_valid && !psel ##1 !alarm_gone_valid && !psel;
  endsequence
  a_one_wait: assert property (s_access |=> pready)
    else $error("ready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without ready or with data");
  a_alarm_flag: assert property (s_quiet_alarm |=> drive_status_word[7])
    else $error("alarm flag not set after an alarm");
  a_flag_cause: assert property ($rose(drive_status_word[7]) |-> $past(alarm_in_valid, 2))
    else $error("alarm flag rose without an alarm");
  a_status_spare: assert property ((drive_status_word & 16'hff77) == 16'h0)
    else $error("unused status bits set");
  a_boot_dark: assert property (ready_led_red && ready_led_green |->
    !(bus_fault_led_red || bus_fault_led_green || link_led || safety_led))
    else $error("state leds lit during start-up");
  a_reset_orange: assert property ($rose(presetn) |-> ready_led_red && ready_led_green)
    else $error("ready led not orange after reset");
endmodule // diag_led_alarm_buffer_sva
// names match the design ports one to one
bind diag_led_alarm_buffer diag_led_alarm_buffer_sva i_diag_led_alarm_buffer_sva (.*);
`default_nettype wire

// File: led_panel_model.sv
`timescale 1ns/1ns
`default_nettype none
module led_panel_model (
  input wire logic pclk, // clock
  input wire logic clr, // restart counts
  input wire logic [5:0] leds, // led levels
  output logic [47:0] edge_cnt // 8 bits per led
);
  logic [5:0] last_r; // levels seen last edge
  // count level changes; a flashing lamp shows as many edges per window
  always @(posedge pclk) begin
    last_r <= leds;
    for (int i = 0; i < 6; i++) begin
      if (clr) begin
        edge_cnt[i*8 +: 8] <= 8'h00;
      end else if (leds[i] !== last_r[i]) begin
        edge_cnt[i*8 +: 8] <= edge_cnt[i*8 +: 8] + 8'h01;
      end
    end
  end
endmodule // led_panel_model
`default_nettype wire

// File: diag_led_alarm_buffer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module diag_led_alarm_buffer_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, afix, aflt;
  logic ain, agone, rr, rg, br, bg, lk, sf;
  logic [15:0] acode, gcode, dsw;
  logic [47:0] edge_cnt;
  int miscompares, compares;
  // fast half period of 4 cycles keeps each led window at 64 cycles
  diag_led_alarm_buffer #(.FLASH_TICK_CYC(32'd4)) i_diag_led_alarm_buffer (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_in_valid(ain), .alarm_in_code(acode), .alarm_in_fixed(afix),
    .alarm_in_float(aflt), .alarm_gone_valid(agone), .alarm_gone_code(gcode), .drive_status_word(dsw),
    .ready_led_red(rr), .ready_led_green(rg), .bus_fault_led_red(br), .bus_fault_led_green(bg),
    .link_led(lk), .safety_led(sf));
  led_panel_model i_led_panel_model (.pclk(pclk), .clr(clr), .leds({sf, lk, bg, br, rg, rr}),
    .edge_cnt(edge_cnt));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; data and error taken at the ready edge only
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1); // only the watchdog ends a hung wait
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, rdata, e);
  endtask
  task alarm(input logic [15:0] c);
    @(posedge pclk);
    ain <= 1'b1;
    acode <= c;
    afix <= {16'h0, c};
    aflt <= {c, 16'h0};
    @(posedge pclk);
    ain <= 1'b0;
  endtask
  task gone(input logic [15:0] c);
    @(posedge pclk);
    agone <= 1'b1;
    gcode <= c;
    @(posedge pclk);
    agone <= 1'b0;
  endtask
  task entry(input logic [5:0] i, input logic [31:0] e);
    apb(1'b1, 8'h0c, {26'h0, i});
    rd("alarm entry", 8'h10, e);
  endtask
  // settle, then count edges over 64 cycles; steady lamps checked by level
  task led_case(input logic [31:0] c, input int b, input logic [7:0] e, input logic l);
    apb(1'b1, 8'h00, c);
    repeat (8) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (64) @(posedge pclk);
    #1;
    chk("led edges", {24'h0, edge_cnt[b*8 +: 8]}, {24'h0, e});
    apb(1'b0, 8'h1c, 32'h0);
    if (e == 8'h00) chk("led level", {31'h0, rdata[b]}, {31'h0, l});
  endtask
  task t_reset;
    rd("leds", 8'h1c, 32'h3);
    rd("status", 8'h04, 32'h0);
    rd("unmapped", 8'h24, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
  endtask
  task t_leds;
    led_case(32'h1, 1, 0, 1);
    led_case(32'h3, 1, 4, 0);
    led_case(32'h5, 1, 16, 0);
    led_case(32'h9, 0, 4, 0);
    led_case(32'h11, 0, 16, 0);
    led_case(32'h21, 0, 16, 0);
    led_case(32'h21, 2, 16, 0);
    led_case(32'h41, 4, 0, 1);
    led_case(32'h81, 4, 4, 0);
    led_case(32'h1, 4, 0, 0);
    led_case(32'h401, 3, 0, 1);
    led_case(32'h801, 2, 4, 0);
    led_case(32'h1, 2, 16, 0);
    led_case(32'h1001, 2, 10, 0);
    led_case(32'h1001, 3, 10, 0);
    led_case(32'h101, 2, 0, 0);
    led_case(32'h10101, 2, 0, 0);
    led_case(32'h12101, 2, 4, 0);
    led_case(32'h14101, 2, 16, 0);
    led_case(32'h1000001, 5, 0, 1);
    led_case(32'h2000001, 5, 4, 0);
    led_case(32'h4000001, 5, 16, 0);
    led_case(32'h201, 3, 0, 1);
    led_case(32'h10000201, 3, 16, 0);
    led_case(32'h20000201, 3, 4, 0);
    led_case(32'h30000201, 2, 0, 1);
    led_case(32'h40000201, 2, 4, 0);
    led_case(32'h50000201, 2, 8, 0);
  endtask
  task t_buffer;
    apb(1'b1, 8'h20, 32'h1);
    rd("leds", 8'h1c, 32'h3);
    rd("counter", 8'h08, 32'h0);
    alarm(16'h0011);
    entry(6'd0, 32'h8000_0011);
    rd("fixed", 8'h14, 32'h11);
    rd("float", 8'h18, 32'h0011_0000);
    alarm(16'h0022);
    rd("counter", 8'h08, 32'h2);
    entry(6'd0, 32'h8000_0011);
    rd("status", 8'h04, 32'h80);
    gone(16'h0011);
    gone(16'h0022);
    rd("status", 8'h04, 32'h0);
    entry(6'd1, 32'hc000_0022);
  endtask
  task t_full;
    apb(1'b1, 8'h20, 32'h1);
    for (int i = 1; i <= 9; i++) alarm(i[15:0]);
    entry(6'd6, 32'h8000_0009);
    entry(6'd7, 32'h8000_0008);
    rd("counter", 8'h08, 32'h9);
    gone(16'h0002);
    gone(16'h0004);
    alarm(16'h000a);
    entry(6'd8, 32'hc000_0004);
    entry(6'd9, 32'hc000_0002);
    entry(6'd1, 32'h8000_0003);
    entry(6'd6, 32'h8000_000a);
    gone(16'h0001);
    apb(1'b1, 8'h08, 32'h0);
    entry(6'd8, 32'hc000_0001);
    entry(6'd10, 32'hc000_0002);
    entry(6'd0, 32'h8000_0003);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // whole run is near 2500 cycles; 20000 cycles cuts a hang
  initial begin
    #200000;
    miscompares++;
    summarize;
  end
  initial begin
    {presetn, psel, penable, pwrite, clr, ain, agone} = 7'h0;
    {paddr, pwdata, acode, gcode, afix, aflt} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_leds;
    t_buffer;
    t_full;
    summarize;
  end
endmodule // diag_led_alarm_buffer_bench
`default_nettype wire
